// >>> rtl/pfs_pkg.sv
package pfs_pkg;

    // Register bus geometry.
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          FIELD_W         = 4;
    localparam int          NUM_PINS        = 9;
    localparam int          NUM_SLOTS       = 5;

    // Register byte addresses.
    localparam logic [7:0]  ADDR_CTRL_18    = 8'h00;
    localparam logic [7:0]  ADDR_CTRL_19    = 8'h04;

    // Reset values.
    localparam logic [31:0] RST_CTRL_18     = 32'h0000_0000;
    localparam logic [31:0] RST_CTRL_19     = 32'h0000_0000;

    // Bits held by this block; all other bits read as zero.
    localparam logic [31:0] IMPL_CTRL_18    = 32'h000f_ffff;
    localparam logic [31:0] IMPL_CTRL_19    = 32'hffff_0000;

    // Field positions (least significant bit of each 4-bit field).
    localparam int          SEL18_B19_16_LSB = 16;
    localparam int          SEL18_B15_12_LSB = 12;
    localparam int          SEL18_B11_8_LSB  = 8;
    localparam int          SEL18_B7_4_LSB   = 4;
    localparam int          SEL18_B3_0_LSB   = 0;
    localparam int          SEL19_B31_28_LSB = 28;
    localparam int          SEL19_B27_24_LSB = 24;
    localparam int          SEL19_B23_20_LSB = 20;
    localparam int          SEL19_B19_16_LSB = 16;

    // Selection codes; each maps to one function slot.
    localparam logic [3:0]  CODE_SLOT0      = 4'h0;
    localparam logic [3:0]  CODE_SLOT1      = 4'h1;
    localparam logic [3:0]  CODE_SLOT2      = 4'h2;
    localparam logic [3:0]  CODE_SLOT3      = 4'h4;
    localparam logic [3:0]  CODE_SLOT4      = 4'h8;

    // Slots that carry a real function on each pin, pin 8 first.
    localparam logic [NUM_PINS-1:0][NUM_SLOTS-1:0] PIN_SLOT_MASK = {
        5'h1f,  // Pin 8: codes 0, 1h, 2h, 4h, 8h.
        5'h1b,  // Pin 7: codes 0, 1h, 4h, 8h.
        5'h15,  // Pin 6: codes 0, 2h, 8h.
        5'h12,  // Pin 5: codes 1h, 8h.
        5'h1f,
        5'h1f,
        5'h1f,
        5'h1f,
        5'h1f
    };

    // Bus responses.
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

// >>> rtl/pfs_pin_cell.sv
module pfs_pin_cell #(
    parameter logic [4:0] SLOT_MASK = 5'h1f
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] sel,
    input  wire logic [4:0] fn_out,
    input  wire logic [4:0] fn_oe,
    input  wire logic       pin_in,
    output logic            pin_out,
    output logic            pin_oe,
    output logic [4:0]      fn_in
);

    typedef struct packed {
        logic       pin_out;
        logic       pin_oe;
        logic [4:0] fn_in;
    } pfs_cell_st_t;

    pfs_cell_st_t st_r;
    pfs_cell_st_t st_nxt;
    logic [4:0]   slot;

    always_comb begin
        unique case (sel)
            pfs_pkg::CODE_SLOT0: slot = 5'h01;
            pfs_pkg::CODE_SLOT1: slot = 5'h02;
            pfs_pkg::CODE_SLOT2: slot = 5'h04;
            pfs_pkg::CODE_SLOT3: slot = 5'h08;
            pfs_pkg::CODE_SLOT4: slot = 5'h10;
            // Reserved codes route nothing, so the pin floats and no function sees it.
            default:             slot = 5'h00;
        endcase
        slot           = slot & SLOT_MASK;
        st_nxt.pin_out = |(slot & fn_out); // R12
        st_nxt.pin_oe  = |(slot & fn_oe); // R12
        st_nxt.fn_in   = slot & {5{pin_in}}; // R12
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.pin_out;
    assign pin_oe  = st_r.pin_oe;
    assign fn_in   = st_r.fn_in;

endmodule // pfs_pin_cell

// >>> rtl/pfs_pin_select.sv
// How it works
// R1: Ctrl18 bits 19-16 route pin 0 functions.
// R2: Ctrl18 bits 15-12 route pin 1 functions.
// R3: Ctrl18 bits 11-8 route pin 2 functions.
// R4: Ctrl18 bits 7-4 route pin 3 functions.
// R5: Ctrl18 bits 3-0 route pin 4 functions.
// R6: Ctrl19 bits 31-28: debug clock or GPIO.
// R7: Ctrl19 bits 27-24 route pin 6 functions.
// R8: Ctrl19 bits 23-20 route pin 7 functions.
// R9: Ctrl19 bits 19-16 route pin 8 functions.
// R10: Ctrl19 fields read/write, reset to zero.
// R11: Software never writes reserved codes.
// R12: New code acts next edge; one function.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
module pfs_pin_select (
    input  wire logic                                    CORE_CLK,
    input  wire logic                                    ARST_N,
    input  wire logic [7:0]                              S_AXI_AWADDR,
    input  wire logic [2:0]                              S_AXI_AWPROT,
    input  wire logic                                    S_AXI_AWVALID,
    output logic                                         S_AXI_AWREADY,
    input  wire logic [31:0]                             S_AXI_WDATA,
    input  wire logic [3:0]                              S_AXI_WSTRB,
    input  wire logic                                    S_AXI_WVALID,
    output logic                                         S_AXI_WREADY,
    output logic [1:0]                                   S_AXI_BRESP,
    output logic                                         S_AXI_BVALID,
    input  wire logic                                    S_AXI_BREADY,
    input  wire logic [7:0]                              S_AXI_ARADDR,
    input  wire logic [2:0]                              S_AXI_ARPROT,
    input  wire logic                                    S_AXI_ARVALID,
    output logic                                         S_AXI_ARREADY,
    output logic [31:0]                                  S_AXI_RDATA,
    output logic [1:0]                                   S_AXI_RRESP,
    output logic                                         S_AXI_RVALID,
    input  wire logic                                    S_AXI_RREADY,
    input  wire logic [8:0]                              PIN_IN,
    output logic [8:0]                                   PIN_OUT,
    output logic [8:0]                                   PIN_OE,
    input  wire logic [8:0][4:0]                         FUNC_OUT,
    input  wire logic [8:0][4:0]                         FUNC_OE,
    output logic [8:0][4:0]                              FUNC_IN
);

    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] ctrl_18;
        logic [31:0] ctrl_19;
    } pfs_state_t;

    pfs_state_t st_r;
    pfs_state_t st_nxt;

    logic [8:0][3:0] pin_sel;
    logic [31:0]     wmask;

    // Field to pin order: pin 0..4 from the first register, 5..8 from the second.
    always_comb begin
        pin_sel[0] = st_r.ctrl_18[pfs_pkg::SEL18_B19_16_LSB +: pfs_pkg::FIELD_W]; // R1
        pin_sel[1] = st_r.ctrl_18[pfs_pkg::SEL18_B15_12_LSB +: pfs_pkg::FIELD_W]; // R2
        pin_sel[2] = st_r.ctrl_18[pfs_pkg::SEL18_B11_8_LSB +: pfs_pkg::FIELD_W]; // R3
        pin_sel[3] = st_r.ctrl_18[pfs_pkg::SEL18_B7_4_LSB +: pfs_pkg::FIELD_W]; // R4
        pin_sel[4] = st_r.ctrl_18[pfs_pkg::SEL18_B3_0_LSB +: pfs_pkg::FIELD_W]; // R5
        pin_sel[5] = st_r.ctrl_19[pfs_pkg::SEL19_B31_28_LSB +: pfs_pkg::FIELD_W]; // R6
        pin_sel[6] = st_r.ctrl_19[pfs_pkg::SEL19_B27_24_LSB +: pfs_pkg::FIELD_W]; // R7
        pin_sel[7] = st_r.ctrl_19[pfs_pkg::SEL19_B23_20_LSB +: pfs_pkg::FIELD_W]; // R8
        pin_sel[8] = st_r.ctrl_19[pfs_pkg::SEL19_B19_16_LSB +: pfs_pkg::FIELD_W]; // R9
    end

    always_comb begin
        st_nxt = st_r;
        wmask  = {{8{st_r.w_strb[3]}}, {8{st_r.w_strb[2]}},
                  {8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}};

        // Address and data may arrive in either order; each is held until both are in.
        if (S_AXI_AWVALID && st_r.awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && st_r.wready) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = S_AXI_WDATA;
            st_nxt.w_strb = S_AXI_WSTRB;
        end

        if (st_r.bvalid && S_AXI_BREADY) begin
            st_nxt.bvalid = 1'b0;
        end

        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = pfs_pkg::RESP_OKAY;
            unique case (st_r.aw_addr)
                pfs_pkg::ADDR_CTRL_18: begin
                    st_nxt.ctrl_18 = ((st_r.ctrl_18 & ~wmask) | (st_r.w_data & wmask))
                                     & pfs_pkg::IMPL_CTRL_18;
                end
                pfs_pkg::ADDR_CTRL_19: begin
                    st_nxt.ctrl_19 = ((st_r.ctrl_19 & ~wmask) | (st_r.w_data & wmask))
                                     & pfs_pkg::IMPL_CTRL_19; // R10
                end
                default: begin
                    st_nxt.bresp = pfs_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Reserved codes are stored as written; the pin cell gives them no route.
        if (st_r.rvalid && S_AXI_RREADY) begin
            st_nxt.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = pfs_pkg::RESP_OKAY;
            unique case (S_AXI_ARADDR)
                pfs_pkg::ADDR_CTRL_18: begin
                    st_nxt.rdata = st_r.ctrl_18;
                end
                pfs_pkg::ADDR_CTRL_19: begin
                    st_nxt.rdata = st_r.ctrl_19; // R10
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.rresp = pfs_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Ready flags are registered so every bus output leaves a flip-flop.
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r         <= '0;
            st_r.ctrl_18 <= pfs_pkg::RST_CTRL_18;
            st_r.ctrl_19 <= pfs_pkg::RST_CTRL_19; // R10
        end else begin
            st_r <= st_nxt;
        end
    end

    assign S_AXI_AWREADY = st_r.awready;
    assign S_AXI_WREADY  = st_r.wready;
    assign S_AXI_BVALID  = st_r.bvalid;
    assign S_AXI_BRESP   = st_r.bresp;
    assign S_AXI_ARREADY = st_r.arready;
    assign S_AXI_RVALID  = st_r.rvalid;
    assign S_AXI_RDATA   = st_r.rdata;
    assign S_AXI_RRESP   = st_r.rresp;

    // One registered cell per pin keeps the pin path a single flop deep.
    for (genvar p = 0; p < pfs_pkg::NUM_PINS; p++) begin : g_pin
        pfs_pin_cell #(
            .SLOT_MASK (pfs_pkg::PIN_SLOT_MASK[p])
        ) u_cell (
            .clk     (CORE_CLK),
            .arst_n  (ARST_N),
            .sel     (pin_sel[p]),
            .fn_out  (FUNC_OUT[p]),
            .fn_oe   (FUNC_OE[p]),
            .pin_in  (PIN_IN[p]),
            .pin_out (PIN_OUT[p]),
            .pin_oe  (PIN_OE[p]),
            .fn_in   (FUNC_IN[p])
        ); // R12
    end

endmodule // pfs_pin_select

// >>> verification/pfs_pin_select_properties.sv
module pfs_pin_select_checker (
    input wire logic            CORE_CLK,
    input wire logic            ARST_N,
    input wire logic            S_AXI_AWVALID,
    input wire logic            S_AXI_AWREADY,
    input wire logic            S_AXI_WVALID,
    input wire logic            S_AXI_WREADY,
    input wire logic            S_AXI_BVALID,
    input wire logic            S_AXI_BREADY,
    input wire logic            S_AXI_ARVALID,
    input wire logic            S_AXI_ARREADY,
    input wire logic            S_AXI_RVALID,
    input wire logic            S_AXI_RREADY,
    input wire logic [8:0]      PIN_IN,
    input wire logic [8:0]      PIN_OE,
    input wire logic [8:0][4:0] FUNC_OE,
    input wire logic [8:0][4:0] FUNC_IN
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    logic       aw_t, w_t, ar_t, multi;
    logic [8:0] any_oe, fin_any;
    assign aw_t = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_t  = S_AXI_WVALID && S_AXI_WREADY;
    assign ar_t = S_AXI_ARVALID && S_AXI_ARREADY;
    always_comb begin
        multi = 1'b0;
        for (int p = 0; p < 9; p++) begin
            any_oe[p]  = |FUNC_OE[p];
            fin_any[p] = |FUNC_IN[p];
            if (!$onehot0(FUNC_IN[p])) multi = 1'b1;
        end
    end
    a_b_after_both: assert property (aw_t && w_t |-> ##2 S_AXI_BVALID)
        else $error("write response not two cycles after address and data");
    a_b_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
    a_ready_back: assert property (S_AXI_BVALID && S_AXI_BREADY |=> S_AXI_AWREADY && !S_AXI_BVALID)
        else $error("write channel not reopened after response");
    a_r_after_ar: assert property (ar_t |-> ##1 S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read data not one cycle after address");
    a_r_done: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
        else $error("read channel not reopened after data");
    a_oe_cause: assert property ((PIN_OE & ~$past(any_oe)) == 9'h000)
        else $error("pin driven without any function enable");
    a_fin_cause: assert property ((fin_any & ~$past(PIN_IN)) == 9'h000)
        else $error("function input high while pin was low");
    a_fin_single: assert property (!multi)
        else $error("pin delivered to more than one function");
    c_write: cover property (aw_t && w_t);
    c_read: cover property (ar_t);
    c_all_pins: cover property (PIN_OE == 9'h1ff);
endmodule // pfs_pin_select_checker

bind pfs_pin_select pfs_pin_select_checker u_pfs_pin_select_checker (.*);

// >>> verification/pfs_pad_model.sv
module pfs_pad_model (
    input  wire logic [4:0]      hot,
    input  wire logic [8:0]      level,
    output logic [8:0]           pin_in,
    output logic [8:0][4:0]      func_out,
    output logic [8:0][4:0]      func_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // Every pin is offered the same slot vector hot, so the pin shows whether a slot set in hot is routed.
    assign pin_in   = level;
    assign func_out = {9{hot}};
    assign func_oe  = {9{hot}};
endmodule // pfs_pad_model

// >>> verification/pfs_pin_select_tb.sv
module pfs_pin_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic            clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0]      awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]     wdata = 32'h0, rdata;
    logic            awready, wready, bvalid, arready, rvalid;
    logic [1:0]      bresp, rresp;
    logic [8:0]      pin_in, pin_out, pin_oe, level = 9'h1ff;
    logic [4:0]      hot = 5'h00;
    logic [3:0]      wstrb = 4'hf;
    logic [8:0][4:0] func_out, func_oe, func_in, exp_in;
    int              mismatches = 0, n_tests = 0, cyc = 0;
    localparam logic [8:0] VALID [6] = '{9'h1df, 9'h1bf, 9'h15f, 9'h19f, 9'h1ff, 9'h000};
    localparam logic [3:0] CODE [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
    pfs_pin_select u_pfs_pin_select (
        .CORE_CLK(clk), .ARST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
        .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .FUNC_OUT(func_out), .FUNC_OE(func_oe), .FUNC_IN(func_in));
    pfs_pad_model u_pfs_pad_model (.hot(hot), .level(level), .pin_in(pin_in),
        .func_out(func_out), .func_oe(func_oe));
    always #12.5 clk = ~clk;
    task automatic chk(input string n, input logic [44:0] got, input logic [44:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Handshakes are judged at the falling edge, where every flop output has settled.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic       aw_hs, w_hs, b_hs;
        logic [1:0] b_rsp;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge clk);
            aw_hs = awvalid && awready;
            w_hs  = wvalid && wready;
            b_hs  = bvalid;
            b_rsp = bresp;
            @(posedge clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end while (!b_hs);
        chk("write response", 45'(b_rsp), 45'(r));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic        ar_hs, r_hs;
        logic [31:0] r_dat;
        logic [1:0]  r_rsp;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clk);
            ar_hs = arvalid && arready;
            r_hs  = rvalid;
            r_dat = rdata;
            r_rsp = rresp;
            @(posedge clk);
            if (ar_hs) arvalid <= 1'b0;
        end while (!r_hs);
        chk("read data", 45'(r_dat), 45'(d));
        chk("read response", 45'(r_rsp), 45'(r));
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h04, 32'h0, 2'h0);
        wr(8'h04, 32'hffff_ffff, 2'h0);
        rd(8'h04, 32'hffff_0000, 2'h0);
        wstrb <= 4'h8;
        wr(8'h04, 32'h0000_0000, 2'h0);
        wstrb <= 4'hf;
        rd(8'h04, 32'h00ff_0000, 2'h0);
        wr(8'h00, 32'hffff_ffff, 2'h0);
        rd(8'h00, 32'h000f_ffff, 2'h0);
        wr(8'h08, 32'h1, 2'h2);
        rd(8'h08, 32'h0, 2'h2);
        // The last pass writes a reserved code on purpose; nothing may be routed.
        for (int i = 0; i < 6; i++) begin
            level <= 9'h1ff;
            wr(8'h00, 32'({5{CODE[i]}}), 2'h0);
            wr(8'h04, {{4{CODE[i]}}, 16'h0000}, 2'h0);
            hot <= (i < 5) ? 5'h01 << i : 5'h1f;
            repeat (2) @(posedge clk);
            for (int p = 0; p < 9; p++) exp_in[p] = VALID[i][p] ? hot : 5'h00;
            chk("pin drive", 45'(pin_out), 45'(VALID[i]));
            chk("pin enable", 45'(pin_oe), 45'(VALID[i]));
            chk("function input", func_in, exp_in);
            hot <= ~hot;
            level <= 9'h000;
            repeat (2) @(posedge clk);
            chk("unselected slot drive", 45'(pin_out), 45'h0);
            chk("unselected slot enable", 45'(pin_oe), 45'h0);
            chk("function input idle", func_in, 45'h0);
        end
        // A reset in mid-run must bring every field back to code 0.
        rst_n <= 1'b0;
        hot <= 5'h01;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("pin enable after reset", 45'(pin_oe), 45'(VALID[0]));
        rd(8'h04, 32'h0, 2'h0);
        end_of_test();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            end_of_test();
        end
    end
endmodule // pfs_pin_select_tb
